//--- src/eeprom_pkg.sv
// Shared constants and types of the serial memory port.
package eeprom_pkg;

	// ----------------------------------------
	// Array shape
	// ----------------------------------------
	localparam int unsigned BYTES       = 2048;
	localparam int unsigned ADDR_W      = 11;
	localparam int unsigned ADDR_W_X16  = 10;
	localparam int unsigned WORD_W      = 16;
	localparam int unsigned BYTE_W      = 8;
	localparam logic [7:0]  ERASED_BYTE = 8'hff;

	// ----------------------------------------
	// Instruction framing
	// ----------------------------------------
	localparam logic [4:0] HDR_LAST_X16  = 5'h0b;
	localparam logic [4:0] HDR_LAST_X8   = 5'h0c;
	localparam logic [4:0] DATA_LAST_X16 = 5'h0f;
	localparam logic [4:0] DATA_LAST_X8  = 5'h07;
	localparam logic [1:0] OP_EXT        = 2'h0;
	localparam logic [1:0] OP_WRITE      = 2'h1;
	localparam logic [1:0] OP_READ       = 2'h2;
	localparam logic [1:0] OP_ERASE      = 2'h3;
	localparam logic [1:0] EXT_DISABLE   = 2'h0;
	localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
	localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
	localparam logic [1:0] EXT_ENABLE    = 2'h3;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned T_WRITE_MS    = 10;
	localparam int unsigned WRITE_CYC     = (T_WRITE_MS * 1000000) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Program queue
	// ----------------------------------------
	localparam int unsigned QUEUE_DEPTH = 16;
	localparam int unsigned ITEM_W      = 2 + 1 + ADDR_W + WORD_W;

	typedef enum logic [1:0] {
		PK_WRITE,
		PK_ERASE,
		PK_ERASE_ALL,
		PK_WRITE_ALL
	} prog_kind_t;

endpackage : eeprom_pkg

//--- src/prog_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module prog_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             clk,       // System clock
	input  wire logic             rst_b,     // Synchronous reset, active low
	input  wire logic [WIDTH-1:0] in_data,   // Word to store
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	output logic      [WIDTH-1:0] out_data,  // Oldest word
	output logic                  out_valid, // Oldest word present
	input  wire logic             out_ready  // Drain side takes the word
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_b)
		(cnt_q == (PW+1)'(DEPTH)) |-> !push) else $error("fifo written while full");

endmodule : prog_fifo

//--- src/serial_eeprom_port.sv
// Three-wire serial memory port with self-timed programming.
//
// Behaviour
// (R1) The array is 1024 words of 16 bits with the width strap high and 2048 words of 8 bits with it low.
// (R2) An unconnected width strap reads as high, giving the 16-bit organization.
// (R3) Chip select enables the port and all access runs over serial in, serial out and shift clock.
// (R4) A read instruction decodes its address and shifts the addressed word out on serial out.
// (R5) Each program cycle runs on internal timing and ends within 10 ms.
// (R6) A write needs no prior erase of its location.
// (R7) Programming happens only in the enabled state and a write in the disabled state leaves the array alone.
// (R8) After a program cycle starts, raising chip select shows ready or busy on serial out.
// (R9) An instruction starts after chip select rises with a one start bit, a two-bit opcode and the address.
// (R10) Read data changes on shift clock rising edges and is led by one dummy zero bit.
// (R11) The read opcode is 10 followed by 11 address bits in 8-bit or 10 in 16-bit organization.
// (R12) Busy shows low and ready high, and chip select low floats serial out and aborts framing.
`timescale 1ns/1ps
module serial_eeprom_port #(
	parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYC
) (
	input  wire logic clk,             // System clock, 250 MHz
	input  wire logic rst_b,           // Synchronous reset, active low
	input  wire logic chip_select,     // Chip select pin
	input  wire logic shift_clock,     // Shift clock pin
	input  wire logic serial_in,       // Serial data in pin
	input  wire logic word_width_strap, // Organization strap, high for 16-bit words
	input  wire logic strap_open,      // Strap pin left unconnected
	output logic      serial_out,      // Serial data out level
	output logic      serial_out_oe_b  // Serial out enable, low while driving
);

	typedef enum logic [2:0] {
		F_IDLE,
		F_HDR,
		F_DATA,
		F_READ,
		F_DONE
	} frame_t;

	typedef enum logic {
		P_IDLE,
		P_PROG
	} prog_t;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] cs_s;
	logic [2:0] shclk_s;
	logic [1:0] sin_s;
	logic [1:0] strap_s;
	logic [1:0] open_s;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cs_s    <= '0;
			shclk_s <= '0;
			sin_s   <= '0;
			strap_s <= '0;
			open_s  <= '0;
		end else begin
			cs_s    <= {cs_s[1:0], chip_select};
			shclk_s <= {shclk_s[1:0], shift_clock};
			sin_s   <= {sin_s[0], serial_in};
			strap_s <= {strap_s[0], word_width_strap};
			open_s  <= {open_s[0], strap_open};
		end
	end

	logic cs;
	logic cs_rise;
	logic shclk_rise;
	logic sin_bit;

	assign cs         = cs_s[1]; // R3
	assign cs_rise    = cs_s[1] & ~cs_s[2];
	assign shclk_rise = shclk_s[1] & ~shclk_s[2] & cs_s[1];
	assign sin_bit    = sin_s[1];

	// ----------------------------------------
	// Array and address mapping
	// ----------------------------------------
	logic [7:0] mem_q [eeprom_pkg::BYTES];

	function automatic logic [10:0] byte_idx(input logic [10:0] a, input logic x16, input logic hi);
		byte_idx = x16 ? {a[9:0], hi} : a; // R1
	endfunction : byte_idx

	function automatic logic [10:0] next_addr(input logic [10:0] a, input logic x16);
		logic [10:0] n;
		n = a + 11'h001;
		next_addr = x16 ? {1'b0, n[9:0]} : n;
	endfunction : next_addr

	// ----------------------------------------
	// Instruction framing
	// ----------------------------------------
	frame_t      fstate_q;
	logic [4:0]  cnt_q;
	logic [12:0] hdr_q;
	logic [15:0] data_q;
	logic [15:0] rsh_q;
	logic [10:0] raddr_q;
	logic        x16_q;
	logic        en_q;
	logic        rd_drv_q;
	logic        rd_bit_q;
	logic        pend_q;

	logic [12:0] hdr_n;
	logic [15:0] data_n;
	logic [1:0]  op_w;
	logic [10:0] addr_w;
	logic [1:0]  ext_w;
	logic        hdr_last;
	logic        data_last;
	logic [10:0] ld_addr;
	logic [15:0] ld_word;
	logic        rd_load;
	logic        push;
	logic        push_valid;
	logic        push_ready;
	logic [1:0]  push_kind;

	logic [1:0]  op_h;
	logic [10:0] addr_h;
	logic [10:0] push_addr;

	// The header register stands still in the data phase, so decode it as held there
	assign op_h      = x16_q ? hdr_q[11:10] : hdr_q[12:11];
	assign addr_h    = x16_q ? {1'b0, hdr_q[9:0]} : hdr_q[10:0];
	assign hdr_n     = {hdr_q[11:0], sin_bit};
	assign data_n    = {data_q[14:0], sin_bit};
	assign op_w      = x16_q ? hdr_n[11:10] : hdr_n[12:11]; // R11
	assign addr_w    = x16_q ? {1'b0, hdr_n[9:0]} : hdr_n[10:0];
	assign ext_w     = x16_q ? hdr_n[9:8] : hdr_n[10:9];
	assign hdr_last  = (cnt_q == (x16_q ? eeprom_pkg::HDR_LAST_X16 : eeprom_pkg::HDR_LAST_X8));
	assign data_last = (cnt_q == (x16_q ? eeprom_pkg::DATA_LAST_X16 : eeprom_pkg::DATA_LAST_X8));
	assign rd_load   = shclk_rise & (fstate_q == F_HDR) & hdr_last & (op_w == eeprom_pkg::OP_READ);
	assign ld_addr   = rd_load ? addr_w : next_addr(raddr_q, x16_q);
	// An 8-bit word is left-justified so both widths shift out from bit 15
	assign ld_word   = x16_q ? {mem_q[byte_idx(ld_addr, 1'b1, 1'b1)], mem_q[byte_idx(ld_addr, 1'b1, 1'b0)]}
	                         : {mem_q[byte_idx(ld_addr, 1'b0, 1'b0)], 8'h00};

	always_comb begin
		push_valid = 1'b0;
		push_kind  = eeprom_pkg::PK_WRITE;
		if (shclk_rise && en_q) begin // R7
			if (fstate_q == F_HDR && hdr_last) begin
				if (op_w == eeprom_pkg::OP_ERASE) begin
					push_valid = 1'b1;
					push_kind  = eeprom_pkg::PK_ERASE;
				end else if (op_w == eeprom_pkg::OP_EXT && ext_w == eeprom_pkg::EXT_ERASE_ALL) begin
					push_valid = 1'b1;
					push_kind  = eeprom_pkg::PK_ERASE_ALL;
				end
			end else if (fstate_q == F_DATA && data_last) begin
				push_valid = 1'b1;
				push_kind  = (op_h == eeprom_pkg::OP_WRITE) ? eeprom_pkg::PK_WRITE : eeprom_pkg::PK_WRITE_ALL;
			end
		end
	end

	// A full queue drops the instruction; the host is expected to poll busy first
	assign push = push_valid & push_ready;
	assign push_addr = (push_kind == eeprom_pkg::PK_WRITE_ALL) ? 11'h000 : ((fstate_q == F_DATA) ? addr_h : addr_w);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fstate_q <= F_IDLE;
			cnt_q    <= '0;
			hdr_q    <= '0;
			data_q   <= '0;
			rsh_q    <= '0;
			raddr_q  <= '0;
			x16_q    <= 1'b1;
			en_q     <= 1'b0;
			rd_drv_q <= 1'b0;
			rd_bit_q <= 1'b0;
		end else if (!cs) begin
			fstate_q <= F_IDLE; // R12
			rd_drv_q <= 1'b0;
		end else if (cs_rise) begin
			fstate_q <= F_IDLE; // R9
			x16_q    <= strap_s[1] | open_s[1]; // R2
		end else if (shclk_rise) begin
			case (fstate_q)
				F_IDLE: begin
					if (sin_bit) begin // R9
						fstate_q <= F_HDR;
						cnt_q    <= '0;
						hdr_q    <= '0;
					end
				end
				F_HDR: begin
					hdr_q <= hdr_n;
					cnt_q <= cnt_q + 5'h01;
					if (hdr_last) begin
						fstate_q <= F_DONE;
						cnt_q    <= '0;
						if (op_w == eeprom_pkg::OP_READ) begin // R4
							fstate_q <= F_READ;
							raddr_q  <= ld_addr;
							rsh_q    <= ld_word;
							rd_bit_q <= 1'b0; // R10
							rd_drv_q <= 1'b1;
							cnt_q    <= x16_q ? eeprom_pkg::DATA_LAST_X16 + 5'h01 : eeprom_pkg::DATA_LAST_X8 + 5'h01;
						end else if (op_w == eeprom_pkg::OP_WRITE ||
						             (op_w == eeprom_pkg::OP_EXT && ext_w == eeprom_pkg::EXT_WRITE_ALL)) begin
							fstate_q <= F_DATA;
						end else if (op_w == eeprom_pkg::OP_EXT && ext_w == eeprom_pkg::EXT_ENABLE) begin
							en_q <= 1'b1;
						end else if (op_w == eeprom_pkg::OP_EXT && ext_w == eeprom_pkg::EXT_DISABLE) begin
							en_q <= 1'b0;
						end
					end
				end
				F_DATA: begin
					data_q <= data_n;
					cnt_q  <= cnt_q + 5'h01;
					if (data_last) begin
						fstate_q <= F_DONE;
					end
				end
				F_READ: begin
					// Sequential read: once a word is out the next one follows without a dummy bit
					if (cnt_q == 5'h01) begin
						raddr_q  <= ld_addr;
						rsh_q    <= ld_word;
						cnt_q    <= x16_q ? eeprom_pkg::DATA_LAST_X16 + 5'h01 : eeprom_pkg::DATA_LAST_X8 + 5'h01;
					end else begin
						rsh_q <= {rsh_q[14:0], 1'b0};
						cnt_q <= cnt_q - 5'h01;
					end
					rd_bit_q <= rsh_q[15]; // R10
				end
				F_DONE: begin
					fstate_q <= F_DONE;
				end
				default: begin
					fstate_q <= F_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Program queue and self-timed engine
	// ----------------------------------------
	logic [eeprom_pkg::ITEM_W-1:0] item_w;
	logic                          item_valid;
	prog_t                         pstate_q;
	logic [31:0]                   timer_q;
	logic [eeprom_pkg::ITEM_W-1:0] cur_q;
	logic                          busy;
	logic                          done;

	prog_fifo #(
		.WIDTH(eeprom_pkg::ITEM_W),
		.DEPTH(eeprom_pkg::QUEUE_DEPTH)
	) u_queue (
		.clk      (clk),
		.rst_b    (rst_b),
		.in_data  ({push_kind, x16_q, push_addr, data_n}),
		.in_valid (push_valid),
		.in_ready (push_ready),
		.out_data (item_w),
		.out_valid(item_valid),
		.out_ready(pstate_q == P_IDLE)
	);

	assign busy = item_valid | (pstate_q == P_PROG);
	assign done = (pstate_q == P_PROG) && (timer_q == 32'h0);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pstate_q <= P_IDLE;
			timer_q  <= '0;
			cur_q    <= '0;
		end else begin
			case (pstate_q)
				P_IDLE: begin
					if (item_valid) begin
						pstate_q <= P_PROG;
						cur_q    <= item_w;
						timer_q  <= WRITE_CYCLES - 1; // R5
					end
				end
				P_PROG: begin
					if (timer_q == 32'h0) begin
						pstate_q <= P_IDLE;
					end else begin
						timer_q <= timer_q - 32'h1;
					end
				end
				default: begin
					pstate_q <= P_IDLE;
				end
			endcase
		end
	end

	// Array is nonvolatile, so it has no reset
	always_ff @(posedge clk) begin
		if (done) begin
			case (cur_q[29:28])
				eeprom_pkg::PK_WRITE: begin
					mem_q[byte_idx(cur_q[26:16], cur_q[27], 1'b0)] <= cur_q[7:0]; // R6
					if (cur_q[27]) begin
						mem_q[byte_idx(cur_q[26:16], 1'b1, 1'b1)] <= cur_q[15:8];
					end
				end
				eeprom_pkg::PK_ERASE: begin
					mem_q[byte_idx(cur_q[26:16], cur_q[27], 1'b0)] <= eeprom_pkg::ERASED_BYTE;
					if (cur_q[27]) begin
						mem_q[byte_idx(cur_q[26:16], 1'b1, 1'b1)] <= eeprom_pkg::ERASED_BYTE;
					end
				end
				eeprom_pkg::PK_ERASE_ALL: begin
					for (int i = 0; i < eeprom_pkg::BYTES; i++) begin
						mem_q[i] <= eeprom_pkg::ERASED_BYTE;
					end
				end
				default: begin
					for (int i = 0; i < eeprom_pkg::BYTES; i++) begin
						mem_q[i] <= (cur_q[27] && i[0]) ? cur_q[15:8] : cur_q[7:0];
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Status and output pin
	// ----------------------------------------
	// A start bit ends status display, as the host has moved on to a new instruction
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
		end else if (push) begin
			pend_q <= 1'b1; // R8
		end else if (shclk_rise && fstate_q == F_IDLE && sin_bit) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			serial_out      <= 1'b0;
			serial_out_oe_b <= 1'b1;
		end else begin
			serial_out      <= rd_drv_q ? rd_bit_q : ~busy; // R12
			serial_out_oe_b <= ~(cs & (rd_drv_q | pend_q)); // R8 R12
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_start_seen;
		(fstate_q == F_IDLE) ##1 (fstate_q == F_HDR);
	endsequence

	sequence s_read_begins;
		rd_load && cs ##1 rd_drv_q;
	endsequence

	a_prog_enable_gate: assert property (@(posedge clk) disable iff (!rst_b) // R7
		push |-> en_q) else $error("program queued while disabled");
	a_write_time_bound: assert property (@(posedge clk) disable iff (!rst_b) // R5
		(pstate_q == P_PROG) |-> (timer_q < WRITE_CYCLES)) else $error("program timer out of range");
	a_deselect_float: assert property (@(posedge clk) disable iff (!rst_b) // R12
		!cs |=> serial_out_oe_b && (fstate_q == F_IDLE)) else $error("output driven while deselected");
	a_read_dummy_zero: assert property (@(posedge clk) disable iff (!rst_b) // R10
		s_read_begins |=> (!serial_out && !serial_out_oe_b)) else $error("read not led by a dummy zero");
	a_status_busy_low: assert property (@(posedge clk) disable iff (!rst_b) // R8
		(cs && pend_q && !rd_drv_q && busy) |=> (!serial_out_oe_b && !serial_out)) else $error("busy not shown low");
	a_start_bit_one: assert property (@(posedge clk) disable iff (!rst_b) // R9
		s_start_seen |-> $past(sin_bit)) else $error("frame began without a start bit");
	a_narrow_word_pad: assert property (@(posedge clk) disable iff (!rst_b) // R1
		(rd_load && !x16_q) |=> (rsh_q[7:0] == 8'h00)) else $error("8-bit word not left-justified");
	a_strap_default: assert property (@(posedge clk) disable iff (!rst_b) // R2
		(cs && cs_rise && open_s[1]) |=> x16_q) else $error("open strap not read as 16-bit");
	a_read_address: assert property (@(posedge clk) disable iff (!rst_b) // R4 R11
		rd_load |=> (raddr_q == $past(addr_w))) else $error("read address not taken");

endmodule : serial_eeprom_port

//--- tb/host_model.sv
// Host controller model that drives the three-wire link from the far side.
`timescale 1ns/1ps
module host_model (
	input  wire logic clk,         // System clock, used only to pace the pins
	input  wire logic serial_out,  // Resolved data out wire
	output logic      chip_select, // Select pin
	output logic      shift_clock, // Shift clock pin
	output logic      serial_in    // Serial data to the port
);
	logic last_q;

	initial begin
		chip_select = 1'b0;
		shift_clock = 1'b0;
		serial_in   = 1'b1;
		last_q      = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_clk

	// ----------------------------------------
	// Link cycles
	// ----------------------------------------
	// One 160 ns shift period; data settles a quarter period before the rise
	task automatic shift(input logic b);
		serial_in = b;
		last_q    = b;
		wait_clk(10);
		shift_clock = 1'b1;
		wait_clk(20);
		shift_clock = 1'b0;
		wait_clk(10);
	endtask : shift

	task automatic sel();
		chip_select = 1'b1;
		wait_clk(10);
	endtask : sel

	task automatic start(input int n, input logic [31:0] v);
		sel();
		shift(1'b1);
		for (int i = n - 1; i >= 0; i--) begin
			shift(v[i]);
		end
	endtask : start

	// Released data line shows the inverse so a stale bit cannot pass
	task automatic stop();
		chip_select = 1'b0;
		serial_in   = ~last_q;
		wait_clk(70);
	endtask : stop

	// Sampled late in the period, well after the port has moved its output
	task automatic take(output logic b);
		shift(~last_q);
		b = serial_out;
	endtask : take
endmodule : host_model

//--- tb/serial_eeprom_port_test.sv
// Self-checking bench of the serial memory port against a byte-array model.
`timescale 1ns/1ps
module serial_eeprom_port_test;
	localparam int unsigned WCYC = 400;

	logic        clk;
	logic        rst_b;
	logic        strap;
	logic        strap_open;
	logic        cs;
	logic        shclk;
	logic        sin;
	logic        sdo;
	logic        oe_b;
	wire         do_line;
	int          bad_count;
	int          checks;
	logic [31:0] rng_q;
	logic [7:0]  mem_m [2048];
	logic        enabled;

	assign do_line = oe_b ? 1'bz : sdo;

	host_model u_host (.clk(clk), .serial_out(do_line), .chip_select(cs), .shift_clock(shclk), .serial_in(sin));

	serial_eeprom_port #(.WRITE_CYCLES(WCYC)) u_dut (
		.clk(clk), .rst_b(rst_b), .chip_select(cs), .shift_clock(shclk), .serial_in(sin),
		.word_width_strap(strap), .strap_open(strap_open), .serial_out(sdo), .serial_out_oe_b(oe_b));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rng_q = rng_q ^ (rng_q << 13);
		rng_q = rng_q ^ (rng_q >> 17);
		rng_q = rng_q ^ (rng_q << 5);
		return rng_q;
	endfunction : rnd

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// ----------------------------------------
	// Instructions and model
	// ----------------------------------------
	task automatic prog(input logic [1:0] op, input logic [1:0] code, input logic [10:0] a, input logic [15:0] d);
		int          aw;
		int          dw;
		int          n;
		logic        x16;
		logic        q;
		logic [31:0] v;
		x16 = strap | strap_open;
		aw  = x16 ? 10 : 11;
		dw  = x16 ? 16 : 8;
		if (op == eeprom_pkg::OP_EXT)
			a = 11'(code) << (aw - 2);
		v = (32'(op) << aw) | 32'(a);
		n = 2 + aw;
		if (op == eeprom_pkg::OP_WRITE || (op == eeprom_pkg::OP_EXT && code == eeprom_pkg::EXT_WRITE_ALL)) begin
			v = (v << dw) | (x16 ? 32'(d) : 32'(d[7:0]));
			n = n + dw;
		end
		q = enabled && !(op == eeprom_pkg::OP_EXT && code inside {eeprom_pkg::EXT_ENABLE, eeprom_pkg::EXT_DISABLE});
		if (q) begin
			for (int i = 0; i < 2048; i++) begin
				if (op == eeprom_pkg::OP_EXT && code == eeprom_pkg::EXT_ERASE_ALL)
					mem_m[i] = eeprom_pkg::ERASED_BYTE;
				else if (op == eeprom_pkg::OP_EXT)
					mem_m[i] = (x16 && i[0]) ? d[15:8] : d[7:0];
				else if (x16 ? (i[10:1] == a[9:0]) : (i[10:0] == a)) begin
					if (op == eeprom_pkg::OP_ERASE)
						mem_m[i] = eeprom_pkg::ERASED_BYTE;
					else
						mem_m[i] = (x16 && i[0]) ? d[15:8] : d[7:0];
				end
			end
		end
		if (op == eeprom_pkg::OP_EXT && code == eeprom_pkg::EXT_ENABLE)
			enabled = 1'b1;
		if (op == eeprom_pkg::OP_EXT && code == eeprom_pkg::EXT_DISABLE)
			enabled = 1'b0;
		u_host.start(n, v);
		u_host.stop();
		if (q) begin
			u_host.sel();
			check(16'(do_line), 16'h0000);
			for (int i = 0; i < WCYC + 50 && do_line !== 1'b1; i++)
				u_host.wait_clk(1);
			check(16'(do_line), 16'h0001);
			u_host.stop();
		end
	endtask : prog

	task automatic rd(input logic [10:0] a, input int nw);
		int          aw;
		int          dw;
		int          aa;
		logic        x16;
		logic        b;
		logic [15:0] w;
		x16 = strap | strap_open;
		aw  = x16 ? 10 : 11;
		dw  = x16 ? 16 : 8;
		u_host.start(2 + aw, (32'(eeprom_pkg::OP_READ) << aw) | 32'(x16 ? {1'b0, a[9:0]} : a));
		check(16'(do_line), 16'h0000);
		for (int k = 0; k < nw; k++) begin
			w  = 16'h0000;
			aa = (int'(a) + k) % (x16 ? 1024 : 2048);
			for (int j = 0; j < dw; j++) begin
				u_host.take(b);
				w = {w[14:0], b};
			end
			check(w, x16 ? {mem_m[2 * aa + 1], mem_m[2 * aa]} : {8'h00, mem_m[aa]});
		end
		u_host.stop();
		check(16'(oe_b), 16'h0001);
	endtask : rd

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [10:0] a;
		rst_b      = 1'b0;
		strap      = 1'b1;
		strap_open = 1'b0;
		enabled    = 1'b0;
		rng_q      = 32'h2207ecee;
		bad_count  = 0;
		checks     = 0;
		repeat (20) @(posedge clk);
		#1;
		rst_b = 1'b1;
		prog(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_ENABLE, 11'h000, 16'h0000);
		prog(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_ERASE_ALL, 11'h000, 16'h0000);
		rd(11'h3ff, 2);
		for (int i = 0; i < 3; i++) begin
			r = rnd();
			a = {1'b0, r[9:0]};
			prog(eeprom_pkg::OP_WRITE, 2'h0, a, r[31:16]);
			prog(eeprom_pkg::OP_WRITE, 2'h0, a, ~r[31:16]);
			rd(a, 2);
		end
		prog(eeprom_pkg::OP_ERASE, 2'h0, a, 16'h0000);
		rd(a, 1);
		prog(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_DISABLE, 11'h000, 16'h0000);
		r = rnd();
		prog(eeprom_pkg::OP_WRITE, 2'h0, a, r[15:0]);
		rd(a, 1);
		prog(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_ENABLE, 11'h000, 16'h0000);
		strap = 1'b0;
		a     = r[26:16];
		prog(eeprom_pkg::OP_WRITE, 2'h0, a, {8'h00, r[7:0]});
		rd(a - 11'h001, 3);
		strap_open = 1'b1;
		rd({1'b0, a[10:1]}, 1);
		strap_open = 1'b0;
		prog(eeprom_pkg::OP_EXT, eeprom_pkg::EXT_WRITE_ALL, 11'h000, {8'h00, r[15:8]});
		rd(r[31:21], 2);
		// Instruction cut short by deselect must leave the next one intact
		u_host.start(4, 32'h0000_0009);
		u_host.stop();
		check(16'(oe_b), 16'h0001);
		rd(a, 1);
		results();
	end

	// Whole run needs about 35k clocks; this allows roughly twice that
	initial begin
		#300000;
		bad_count++;
		results();
	end
endmodule : serial_eeprom_port_test
